// ### hdl/rf_drive_select.v
`timescale 1ns/1ps
`default_nettype none
`include "rf_mod_consts.vh"
// Picks the driver resistance code for the present modulation state
module rf_drive_select (
  input wire i_mod_state,
  input wire [3:0] i_ptm_code,
  input wire [3:0] i_pt_code,
  output wire [3:0] o_code,
  output wire o_highz
);
  // Modulated state uses the upper field, idle state the lower
  assign o_code = i_mod_state ? i_ptm_code : i_pt_code;
  // Top code floats the driver instead of a resistance
  assign o_highz = (o_code == `PT_CODE_HIGHZ);
endmodule // rf_drive_select
`default_nettype wire

// ### hdl/rf_mod_consts.vh
`ifndef RF_MOD_CONSTS_VH
`define RF_MOD_CONSTS_VH
// Register byte addresses (offsets are multiples of four: index * 4)
`define REG_AUX_IDX 8'h28
`define REG_PT_IDX 8'h29
`define ADDR_W 12
`define ADDR_AUX 12'h0a0
`define ADDR_PT 12'h0a4
// Aux register fields
`define AUX_REG_AM_OFF 7
`define AUX_EXT_POL 6
`define AUX_EXT_EN 5
`define AUX_DRV_LM 4
`define AUX_RESIST_AM 3
`define AUX_SHAPED_AM 2
`define AUX_RESET 8'h10
`define AUX_WMASK 8'hfc
// Passive target fields
`define PT_MOD_HI 7
`define PT_MOD_LO 4
`define PT_UNMOD_HI 3
`define PT_UNMOD_LO 0
`define PT_RESET 8'h70
`define PT_CODE_HIGHZ 4'hf
// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### hdl/rf_modulation_config_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "rf_mod_consts.vh"
module rf_modulation_config_regs (
  input wire i_clk,
  input wire i_nrst,
  // AXI4-Lite write address
  input wire i_awvalid,
  output reg o_awready,
  input wire [`ADDR_W-1:0] i_awaddr,
  // AXI4-Lite write data
  input wire i_wvalid,
  output reg o_wready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  // AXI4-Lite write response
  output reg o_bvalid,
  input wire i_bready,
  output reg [1:0] o_bresp,
  // AXI4-Lite read address
  input wire i_arvalid,
  output reg o_arready,
  input wire [`ADDR_W-1:0] i_araddr,
  // AXI4-Lite read data
  output reg o_rvalid,
  input wire i_rready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  // Modulation state from the transmit/load-modulation engine
  input wire i_mod_active,
  // Resistive AM modulated-state code from the neighbouring register
  input wire [6:0] i_resistive_am_resistance,
  // Controls toward the RF output stage
  output reg o_regulator_am_enable,
  output reg o_shaped_regulator_am_enable,
  output reg o_resistive_am_enable,
  output reg o_driver_loadmod_enable,
  output reg [6:0] o_resistive_am_code,
  output reg [3:0] o_driver_res_code,
  output reg o_driver_highz,
  output reg o_ext_loadmod_pin,
  output reg o_ext_loadmod_pin_oe_n
);
  //////////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [7:0] aux_q; // Auxiliary modulation setting
  reg [7:0] pt_q; // Passive target drive resistances
  reg [`ADDR_W-1:0] awaddr_q; // Captured write address
  reg aw_have_q; // Write address held
  reg [31:0] wdata_q; // Captured write data
  reg [3:0] wstrb_q; // Captured byte strobes
  reg w_have_q; // Write data held
  wire do_write; // Both halves present, response slot free
  wire [3:0] sel_code; // Selected passive target code
  wire sel_highz; // Selected code floats the driver
  // Field views
  wire reg_am_off = aux_q[`AUX_REG_AM_OFF];
  wire ext_pol = aux_q[`AUX_EXT_POL];
  wire ext_en = aux_q[`AUX_EXT_EN];
  // Bits 1:0 have no view here, so they can steer nothing
  assign do_write = aw_have_q && w_have_q && !o_bvalid;

  //////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  // Readies pulse one cycle at a time; registered, so no path from valid to ready
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= {`ADDR_W{1'b0}};
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
    end else begin
      // Ready only while the slot is empty, so one write at a time
      o_awready <= !aw_have_q && !o_awready && !(i_awvalid && o_awready);
      o_wready <= !w_have_q && !o_wready && !(i_wvalid && o_wready);
      if (i_awvalid && o_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_bvalid <= 1'b1;
        // Unmapped addresses answer with an error and store nothing
        if (awaddr_q == `ADDR_AUX || awaddr_q == `ADDR_PT) begin
          o_bresp <= `RESP_OKAY;
        end else begin
          o_bresp <= `RESP_SLVERR;
        end
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register update; only byte lane 0 carries the 8-bit fields
  // A write without lane 0 still answers OKAY but leaves both registers alone
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      aux_q <= `AUX_RESET;
      pt_q <= `PT_RESET;
    end else if (do_write && wstrb_q[0]) begin
      if (awaddr_q == `ADDR_AUX) begin
        // Reserved bits masked so they never store
        aux_q <= wdata_q[7:0] & `AUX_WMASK;
      end
      if (awaddr_q == `ADDR_PT) begin
        pt_q <= wdata_q[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answer one cycle after address
  // A read that meets a write at one edge sees the older contents
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !o_arready;
      if (i_arvalid && o_arready) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        // Upper bits read zero; reserved aux bits are stored as zero
        case (i_araddr)
          `ADDR_AUX: begin
            o_rdata <= {24'h00_0000, aux_q};
            o_rresp <= `RESP_OKAY;
          end
          `ADDR_PT: begin
            o_rdata <= {24'h00_0000, pt_q};
            o_rresp <= `RESP_OKAY;
          end
          default: begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Passive target code selection by modulation state
  // Kept combinational so the registered stage below adds the only delay
  rf_drive_select u_drive_select (
    .i_mod_state(i_mod_active),
    .i_ptm_code(pt_q[`PT_MOD_HI:`PT_MOD_LO]),
    .i_pt_code(pt_q[`PT_UNMOD_HI:`PT_UNMOD_LO]),
    .o_code(sel_code),
    .o_highz(sel_highz)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Registered controls to the RF stage; one cycle behind the bits
  // Limitation: the pin trails the modulation state by one clock
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_regulator_am_enable <= 1'b1;
      o_shaped_regulator_am_enable <= 1'b0;
      o_resistive_am_enable <= 1'b0;
      o_driver_loadmod_enable <= 1'b1;
      o_resistive_am_code <= 7'h00;
      o_driver_res_code <= 4'h0;
      o_driver_highz <= 1'b0;
      o_ext_loadmod_pin <= 1'b0;
      o_ext_loadmod_pin_oe_n <= 1'b1;
    end else begin
      // Inverted sense: zero means regulator AM runs
      o_regulator_am_enable <= !reg_am_off;
      o_shaped_regulator_am_enable <= aux_q[`AUX_SHAPED_AM];
      o_resistive_am_enable <= aux_q[`AUX_RESIST_AM];
      o_driver_loadmod_enable <= aux_q[`AUX_DRV_LM];
      // Modulated-state resistance only matters while resistive AM is on
      o_resistive_am_code <= aux_q[`AUX_RESIST_AM] ?
        i_resistive_am_resistance : 7'h00;
      // Driver code applies only with driver load modulation enabled
      if (aux_q[`AUX_DRV_LM]) begin
        o_driver_res_code <= sel_code;
        o_driver_highz <= sel_highz;
      end else begin
        o_driver_res_code <= 4'h0;
        o_driver_highz <= 1'b0;
      end
      // Pin released when disabled; polarity flips the active level
      o_ext_loadmod_pin_oe_n <= !ext_en;
      o_ext_loadmod_pin <= ext_en ? (i_mod_active ^ ext_pol) : 1'b0;
    end
  end
endmodule // rf_modulation_config_regs
`default_nettype wire

// ### verif/rf_mod_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rf_mod_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic o_resistive_am_enable,
  input wire logic o_driver_loadmod_enable,
  input wire logic o_driver_highz,
  input wire logic o_ext_loadmod_pin,
  input wire logic o_ext_loadmod_pin_oe_n,
  input wire logic [6:0] i_resistive_am_resistance,
  input wire logic [6:0] o_resistive_am_code,
  input wire logic [3:0] o_driver_res_code
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Both write halves accepted at one edge, no response pending
  sequence s_wr_both;
    i_awvalid && o_awready && i_wvalid && o_wready && !o_bvalid;
  endsequence
  // Read address accepted
  sequence s_rd_take;
    i_arvalid && o_arready;
  endsequence
  // Halves sit in holding slots for one edge, then the response rises
  a_write_answer: assert property (s_wr_both |=> ##1 o_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_take |=> o_rvalid)
    else $error("read data missing");
  a_resp_held: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  a_pin_idle_low: assert property (o_ext_loadmod_pin_oe_n |-> !o_ext_loadmod_pin)
    else $error("pin active while disabled");
  a_highz_code: assert property (
    o_driver_highz == (o_driver_loadmod_enable && o_driver_res_code == 4'hf))
    else $error("high impedance flag wrong");
  a_drv_off_zero: assert property (
    !o_driver_loadmod_enable |-> o_driver_res_code == 4'h0)
    else $error("driver code while disabled");
  a_resam_zero: assert property (
    !o_resistive_am_enable |-> o_resistive_am_code == 7'h00)
    else $error("resistive code while disabled");
  a_resam_follow: assert property (
    o_resistive_am_enable |-> o_resistive_am_code == $past(i_resistive_am_resistance))
    else $error("resistive code not passed");
endmodule // rf_mod_chk
bind rf_modulation_config_regs rf_mod_chk chk (.*);
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rf_mod_consts.vh"
module tb;
  // Bench signals share the port names
  logic i_clk=0, i_nrst=0, i_awvalid=0, i_wvalid=0, i_bready=0, i_arvalid=0, i_rready=0;
  logic i_mod_active=0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_driver_highz;
  logic [11:0] i_awaddr=12'h000, i_araddr=12'h000;
  logic [31:0] i_wdata=32'h0000_0000, o_rdata;
  logic [3:0] i_wstrb=4'h1, o_driver_res_code, cd;
  logic [6:0] i_resistive_am_resistance=7'h00, o_resistive_am_code;
  logic [1:0] o_bresp, o_rresp;
  logic o_regulator_am_enable, o_shaped_regulator_am_enable, o_resistive_am_enable;
  logic o_driver_loadmod_enable, o_ext_loadmod_pin, o_ext_loadmod_pin_oe_n;
  logic [7:0] sd=8'h62, a, p;
  logic [17:0] ex;
  logic [33:0] q[$]; // Expected read answers, oldest first
  logic [1:0] bq[$]; // Expected write responses, oldest first
  int error_cnt=0, comparisons=0, n;
  wire [17:0] rf = {o_regulator_am_enable, o_shaped_regulator_am_enable, o_resistive_am_enable,
    o_driver_loadmod_enable, o_ext_loadmod_pin_oe_n, o_ext_loadmod_pin, o_resistive_am_code,
    o_driver_res_code, o_driver_highz};
  rf_modulation_config_regs dut (.*);
  initial forever #5 i_clk = ~i_clk;
  ////////////////////////////////////////
  task chk(input string nm, input logic [33:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function logic [7:0] lf();
    sd = {sd[6:0], sd[7] ^ sd[5] ^ sd[4] ^ sd[3]};
    return sd;
  endfunction
  // Write: offer both halves, drop each once taken, keep bready until answer
  task wr(input logic [11:0] ad, input logic [7:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= ad;
    i_wdata <= {24'h00_0000, d};
    i_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    if (n == 40) begin
      error_cnt++;
      wrap_up;
    end
    i_bready <= 1'b0;
  endtask
  // Read: note the expectation, the watcher compares it
  task rd(input logic [11:0] ad, input logic [33:0] e);
    q.push_back(e);
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr <= ad;
    i_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    if (n == 40) begin
      error_cnt++;
      wrap_up;
    end
    i_rready <= 1'b0;
  endtask
  // Watchers: each answer taken on the bus consumes the oldest note
  always @(posedge i_clk) begin
    if (o_rvalid && i_rready) chk("rdata", {o_rresp, o_rdata}, q.pop_front());
  end
  always @(posedge i_clk) begin
    if (o_bvalid && i_bready) chk("bresp", o_bresp, bq.pop_front());
  end
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1;
    rd(`ADDR_AUX, 34'h0_0000_0010);
    rd(`ADDR_PT, 34'h0_0000_0070);
    chk("defaults", rf[17:12], 6'b100110);
    $display("reset test done");
    // First pass fixed so the floating code is hit, then random settings
    for (int i = 0; i < 12; i++) begin
      a = i ? lf() : 8'hff;
      p = i ? lf() : 8'hf7;
      a[7] = a[7] | a[2]; // Shaped AM only with regulator AM off
      wr(`ADDR_AUX, a, `RESP_OKAY);
      wr(`ADDR_PT, p, `RESP_OKAY);
      rd(`ADDR_AUX, {26'h000_0000, a & 8'hfc});
      rd(`ADDR_PT, {26'h000_0000, p});
      void'(lf());
      i_mod_active <= i ? sd[2] : 1'b1;
      i_resistive_am_resistance <= sd[6:0];
      repeat (2) @(posedge i_clk);
      #1;
      cd = a[4] ? (i_mod_active ? p[7:4] : p[3:0]) : 4'h0;
      ex = {!a[7], a[2], a[3], a[4], !a[5], a[5] & (i_mod_active ^ a[6]),
        a[3] ? i_resistive_am_resistance : 7'h00, cd, a[4] && cd == 4'hf};
      chk("rf", rf, ex);
    end
    $display("settings test done");
    // Unmapped place and a write with the low lane off
    wr(12'h0a8, 8'h55, `RESP_SLVERR);
    rd(12'h0a8, {`RESP_SLVERR, 32'h0000_0000});
    i_wstrb <= 4'he;
    wr(`ADDR_PT, 8'h12, `RESP_OKAY);
    i_wstrb <= 4'h1;
    rd(`ADDR_PT, {26'h000_0000, p});
    $display("refusal test done");
    // Reset again in mid-run: settings must fall back to their defaults
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(`ADDR_AUX, 34'h0_0000_0010);
    rd(`ADDR_PT, 34'h0_0000_0070);
    chk("defaults", rf[17:12], 6'b100110);
    $display("second reset test done");
    wrap_up;
  end
endmodule // tb
`default_nettype wire
